// ### hw/rtp_pkg.sv
// Purpose: Shared constants for the six-pin real-time output port
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets index byte registers; data sits in the low eight bits
package rtp_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PINS   = 6;
    localparam int unsigned HALF_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_PORT_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PIN_MODE   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_BUF_LOW    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_BUF_HIGH   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_DC_CTRL    = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_INV_TMR    = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_LATCH      = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_PIN_STATE  = 4'h7;

    // Field positions
    localparam int unsigned BIT_OUT_EN     = 7;
    localparam int unsigned BIT_WIDTH_SEL  = 5;
    localparam int unsigned BIT_OUT_SEL    = 7;
    localparam int unsigned BIT_EVEN_MOD   = 6;
    localparam int unsigned BIT_ODD_MOD    = 5;
    localparam int unsigned BIT_INVERT     = 4;
    localparam int unsigned BIT_CHAN_EN    = 7;

    // Writable masks; other bits read as zero
    localparam logic [DATA_W-1:0] MASK_PORT_CTRL = 8'ha0;
    localparam logic [DATA_W-1:0] MASK_PIN_MODE  = 8'h3f;
    localparam logic [DATA_W-1:0] MASK_BUF       = 8'h0f;
    localparam logic [DATA_W-1:0] MASK_DC_CTRL   = 8'hf0;
    localparam logic [DATA_W-1:0] MASK_INV_TMR   = 8'h80;

    localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;
    localparam logic [PINS-1:0]   RST_PINS   = 6'h00;
    localparam logic [DATA_W-1:0] READ_UNMAP = 8'h00;
endpackage

// ### hw/rtp_sync2.sv
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Bits are independent levels
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module rtp_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// ### hw/rtp_pin_cell.sv
// Purpose: Output decision for one pin of the group
// Assumes: Inputs are on the core clock
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/1ps
module rtp_pin_cell (
    input  wire logic i_chan_en,
    input  wire logic i_out_sel,
    input  wire logic i_invert,
    input  wire logic i_modulate,
    input  wire logic i_active,
    input  wire logic i_timer_wave,
    output logic      o_level,
    output logic      o_drive
);
    always_comb begin
        o_drive = i_chan_en;
        if (!i_out_sel) begin
            o_level = i_timer_wave;
        end else if (i_active) begin
            o_level = ~i_invert;
        end else if (i_modulate) begin
            o_level = i_timer_wave;
        end else begin
            o_level = i_invert;
        end
    end
endmodule

// ### hw/realtime_output_port_six_bit.sv
// Purpose: Real-time output port driving six pins from a buffered pattern
// Assumes: Compare event and timer waveform arrive from other clock domains
// Notes:   Pins are registered; enables are active low while driving
//
// Behaviour
// - With output enable set, each compare event copies buffers into the latch.
// - Only latch bits whose pin mode bit is set act as real-time output.
// - Output-select 0 with channel enabled puts the inverter timer wave on pins.
// - Width-select picks six-bit or four-bit operation.
// - Four-bit mode moves only the low buffer; six-bit moves both.
// - Channel enable 0 floats every pin regardless of other settings.
// - Plain mode drives high only when enable, mode and latch bit are set.
// - Inversion flips the plain result.
// - Modulation puts the timer wave on inactive pins; active drives per inversion.
// - DC control holds even modulation bit 6, odd bit 5, inversion bit 4.
// - Even modulation covers pins 0, 2, 4; odd covers 1, 3, 5.
// - Reset clears DC control, selecting timer output without modulation.
// - Low buffer feeds four pattern bits and the high buffer only its low two bits to one transfer.
`timescale 1ns/1ps
module realtime_output_port_six_bit
    import rtp_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_compare_timer_event,
    input  wire logic [PINS-1:0]   i_inverter_timer_pin,
    output logic      [PINS-1:0]   o_pin_out,
    output logic      [PINS-1:0]   o_pin_oe_n
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] port_control_reg;
    logic [PINS-1:0]   pin_mode_reg;
    logic [HALF_W-1:0] pattern_buffer_low;
    logic [HALF_W-1:0] pattern_buffer_high;
    logic [DATA_W-1:0] dc_control_reg;
    logic [DATA_W-1:0] inverter_timer_control_reg;
    logic [PINS-1:0]   latch_reg;

    logic port_output_enable;
    logic width_select;
    logic output_select;
    logic invert_enable;
    logic even_pin_modulation_enable;
    logic odd_pin_modulation_enable;
    logic inverter_channel_enable;

    assign port_output_enable         = port_control_reg[BIT_OUT_EN];
    assign width_select               = port_control_reg[BIT_WIDTH_SEL];
    assign output_select              = dc_control_reg[BIT_OUT_SEL];
    assign even_pin_modulation_enable = dc_control_reg[BIT_EVEN_MOD];
    assign odd_pin_modulation_enable  = dc_control_reg[BIT_ODD_MOD];
    assign invert_enable              = dc_control_reg[BIT_INVERT];
    assign inverter_channel_enable    = inverter_timer_control_reg[BIT_CHAN_EN];

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_control_reg <= RST_BYTE;
        end else if (i_wr && hit(i_addr, OFS_PORT_CTRL)) begin
            port_control_reg <= i_wdata & MASK_PORT_CTRL;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_mode_reg <= RST_PINS;
        end else if (i_wr && hit(i_addr, OFS_PIN_MODE)) begin
            pin_mode_reg <= i_wdata[PINS-1:0];
        end
    end

    // Buffers are filled by software between events
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pattern_buffer_low  <= '0;
            pattern_buffer_high <= '0;
        end else if (i_wr) begin
            if (hit(i_addr, OFS_BUF_LOW)) begin
                pattern_buffer_low <= i_wdata[HALF_W-1:0];
            end
            if (hit(i_addr, OFS_BUF_HIGH)) begin
                pattern_buffer_high <= i_wdata[HALF_W-1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dc_control_reg <= RST_BYTE;
        end else if (i_wr && hit(i_addr, OFS_DC_CTRL)) begin
            dc_control_reg <= i_wdata & MASK_DC_CTRL;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            inverter_timer_control_reg <= RST_BYTE;
        end else if (i_wr && hit(i_addr, OFS_INV_TMR)) begin
            inverter_timer_control_reg <= i_wdata & MASK_INV_TMR;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers and event edge
    // ------------------------------------------------------------
    logic [PINS-1:0] timer_wave;
    logic            event_sync;
    logic            event_prev_reg;
    logic            event_pulse;

    rtp_sync2 #(.W(PINS)) u_wave_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (i_inverter_timer_pin),
        .o_sync     (timer_wave)
    );

    rtp_sync2 #(.W(1)) u_event_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (i_compare_timer_event),
        .o_sync     (event_sync)
    );

    // Event is taken on the rising edge so a long pulse transfers only once
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            event_prev_reg <= 1'b0;
        end else begin
            event_prev_reg <= event_sync;
        end
    end

    assign event_pulse = event_sync & ~event_prev_reg;

    // ------------------------------------------------------------
    // Output latch transfer
    // ------------------------------------------------------------
    // Four-bit mode leaves the top two pins on their last pattern
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_reg <= RST_PINS;
        end else if (event_pulse && port_output_enable) begin
            latch_reg[HALF_W-1:0] <= pattern_buffer_low;
            if (width_select) begin
                latch_reg[PINS-1:HALF_W] <= pattern_buffer_high[PINS-HALF_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-pin output selection
    // ------------------------------------------------------------
    logic [PINS-1:0] level;
    logic [PINS-1:0] drive;
    logic [PINS-1:0] active;

    // Active needs enable, mode bit and latched bit together
    assign active = {PINS{port_output_enable}} & pin_mode_reg & latch_reg;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            rtp_pin_cell u_cell (
                .i_chan_en    (inverter_channel_enable),
                .i_out_sel    (output_select),
                .i_invert     (invert_enable),
                .i_modulate   ((g % 2 == 0) ? even_pin_modulation_enable
                                            : odd_pin_modulation_enable),
                .i_active     (active[g]),
                .i_timer_wave (timer_wave[g]),
                .o_level      (level[g]),
                .o_drive      (drive[g])
            );
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out  <= RST_PINS;
            o_pin_oe_n <= ~RST_PINS;
        end else begin
            o_pin_out  <= level;
            o_pin_oe_n <= ~drive;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= RST_BYTE;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_PORT_CTRL: o_rdata <= port_control_reg;
                OFS_PIN_MODE:  o_rdata <= {2'h0, pin_mode_reg};
                OFS_BUF_LOW:   o_rdata <= {4'h0, pattern_buffer_low};
                OFS_BUF_HIGH:  o_rdata <= {4'h0, pattern_buffer_high};
                OFS_DC_CTRL:   o_rdata <= dc_control_reg;
                OFS_INV_TMR:   o_rdata <= inverter_timer_control_reg;
                OFS_LATCH:     o_rdata <= {2'h0, latch_reg};
                OFS_PIN_STATE: o_rdata <= {2'h0, o_pin_out};
                default:       o_rdata <= READ_UNMAP;
            endcase
        end else begin
            o_rdata <= RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [PINS-1:0] latch_prev;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_prev <= RST_PINS;
        end else begin
            latch_prev <= latch_reg;
        end
    end

    latch_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !($past(event_pulse) && $past(port_output_enable)) |-> latch_reg == latch_prev)
        else $error("latch changed without an enabled event");
    low_xfer_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        event_pulse && port_output_enable |=>
        latch_reg[HALF_W-1:0] == $past(pattern_buffer_low))
        else $error("low buffer not transferred");
    high_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        event_pulse && port_output_enable && !width_select |=>
        latch_reg[PINS-1:HALF_W] == $past(latch_reg[PINS-1:HALF_W]))
        else $error("high half moved in four-bit mode");
    high_xfer_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        event_pulse && port_output_enable && width_select |=>
        latch_reg[PINS-1:HALF_W] == $past(pattern_buffer_high[PINS-HALF_W-1:0]))
        else $error("high buffer not transferred");
    float_pins_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !inverter_channel_enable |=> o_pin_oe_n == '1)
        else $error("pins driven with channel disabled");
    timer_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        inverter_channel_enable && !output_select |=> o_pin_out == $past(timer_wave))
        else $error("timer wave not passed through");
    plain_out_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && !even_pin_modulation_enable && !odd_pin_modulation_enable
        |=> o_pin_out == ($past(active) ^ {PINS{$past(invert_enable)}}))
        else $error("plain output mismatch");
    inv_active_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && invert_enable && active[0] |=> !o_pin_out[0])
        else $error("inverted active pin not low");
    mod_even_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && even_pin_modulation_enable && !active[0]
        |=> o_pin_out[0] == $past(timer_wave[0]))
        else $error("modulated pin lacks timer wave");
    dc_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> dc_control_reg == RST_BYTE)
        else $error("dc control not cleared");
    idle_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !port_output_enable |=> latch_reg == $past(latch_reg))
        else $error("latch moved with output disabled");

    // ------------------------------------------------------------
    // Pin behaviour and register mask checks
    // ------------------------------------------------------------
    // Pins are checked one cycle after the settings that select them
    odd_mod_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && odd_pin_modulation_enable && !active[1]
        |=> o_pin_out[1] == $past(timer_wave[1]))
        else $error("odd pin lacks timer wave");
    even_unmod_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && !even_pin_modulation_enable && !active[0]
        |=> o_pin_out[0] == $past(invert_enable))
        else $error("unmodulated even pin not idle");
    mode_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && !pin_mode_reg[1] && !odd_pin_modulation_enable
        |=> o_pin_out[1] == $past(invert_enable))
        else $error("port-mode pin shows latch data");
    mod_active_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        output_select && even_pin_modulation_enable && active[0]
        |=> o_pin_out[0] == !$past(invert_enable))
        else $error("modulated active pin level wrong");
    drive_pins_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        inverter_channel_enable |=> o_pin_oe_n == '0)
        else $error("pins floated with channel enabled");
    dc_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (dc_control_reg & ~MASK_DC_CTRL) == RST_BYTE)
        else $error("dc control low bits set");
    width_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (port_control_reg & ~MASK_PORT_CTRL) == RST_BYTE)
        else $error("port control spare bits set");
endmodule

// ### test/rtp_partner.sv
// Purpose: Far side of the port: compare timer event and inverter timer waveform
// Assumes: Bench asks for an event with a one-cycle request
// Notes:   Event high 3 cycles (6 when slow), then a 3-cycle low gap
`timescale 1ns/1ps
module rtp_partner
    import rtp_pkg::*;
(
    input  wire logic            i_core_clk,
    input  wire logic            i_rst_n,
    input  wire logic            i_fire,
    input  wire logic            i_slow,
    input  wire logic [PINS-1:0] i_wave_level,
    output logic                 o_event,
    output logic      [PINS-1:0] o_wave
);
    logic [3:0] hold_reg;

    // -------------------------------------------------------------
    // Event pulse
    // -------------------------------------------------------------
    // Requests during the pulse or its gap are dropped, so spacing never shrinks
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_reg <= 4'h0;
        end else if (i_fire && hold_reg == 4'h0) begin
            hold_reg <= i_slow ? 4'h9 : 4'h6;
        end else if (hold_reg != 4'h0) begin
            hold_reg <= hold_reg - 4'h1;
        end
    end
    assign o_event = (hold_reg > 4'h3);
    assign o_wave  = i_wave_level;
endmodule

// ### test/testbench.sv
// Purpose: Self-checking bench for the six-pin real-time output port
// Assumes: Waveform held steady long enough to pass the synchroniser
// Notes:   Table rows carry register settings and the pin result they give
`timescale 1ns/1ps
module testbench;
    import rtp_pkg::*;
    typedef struct {
        logic [7:0] ctrl, mode, low, high, dc, tmr;
        logic [5:0] wave, latch, pins, oe_n;
    } row_s;
    logic            clk, rst_n, wr, rd, fire, slow, evt;
    logic [3:0]      addr;
    logic [7:0]      wdata, rdata, d;
    logic [5:0]      wave_lvl, wave, pin_out, pin_oe_n;
    int              mismatches, cmp_count;
    row_s            rows [7];

    realtime_output_port_six_bit realtime_output_port_six_bit_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_compare_timer_event(evt),
        .i_inverter_timer_pin(wave), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n));
    rtp_partner rtp_partner_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .i_slow(slow),
        .i_wave_level(wave_lvl), .o_event(evt), .o_wave(wave));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Software refills the buffers before requesting the next event
    task automatic event_wait(input logic s);
        @(posedge clk);
        fire <= 1'b1; slow <= s;
        @(posedge clk);
        fire <= 1'b0;
        repeat (14) @(posedge clk);
    endtask
    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 100);
        mismatches++;
        test_done();
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
        fire = 1'b0; slow = 1'b0; wave_lvl = 6'h00;
        mismatches = 0; cmp_count = 0;
        //         ctrl   mode   low    high   dc     tmr    wave   latch  pins   oe_n
        rows[0] = '{8'ha0, 8'h3f, 8'h05, 8'h02, 8'h80, 8'h80, 6'h00, 6'h25, 6'h25, 6'h00};
        rows[1] = '{8'ha0, 8'h0f, 8'h0a, 8'h03, 8'h90, 8'h80, 6'h00, 6'h3a, 6'h35, 6'h00};
        rows[2] = '{8'h80, 8'h3f, 8'h03, 8'h00, 8'hc0, 8'h80, 6'h3f, 6'h33, 6'h37, 6'h00};
        rows[3] = '{8'ha0, 8'h3f, 8'h00, 8'h00, 8'hb0, 8'h80, 6'h0a, 6'h00, 6'h1f, 6'h00};
        rows[4] = '{8'h20, 8'h3f, 8'h0f, 8'h03, 8'h80, 8'h80, 6'h00, 6'h00, 6'h00, 6'h00};
        rows[5] = '{8'ha0, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h80, 6'h15, 6'h00, 6'h15, 6'h00};
        rows[6] = '{8'ha0, 8'h3f, 8'h0f, 8'h03, 8'h80, 8'h00, 6'h00, 6'h3f, 6'h00, 6'h3f};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk({2'b00, pin_oe_n}, 8'h3f);
        rreg(OFS_DC_CTRL, d);
        chk(d, 8'h00);
        foreach (rows[i]) begin
            wreg(OFS_PORT_CTRL, rows[i].ctrl);
            wreg(OFS_PIN_MODE, rows[i].mode);
            wreg(OFS_BUF_LOW, rows[i].low);
            wreg(OFS_BUF_HIGH, rows[i].high);
            wreg(OFS_DC_CTRL, rows[i].dc);
            wreg(OFS_INV_TMR, rows[i].tmr);
            wave_lvl <= rows[i].wave;
            event_wait(1'b0);
            rreg(OFS_LATCH, d);
            chk(d, {2'b00, rows[i].latch});
            chk({2'b00, pin_oe_n}, {2'b00, rows[i].oe_n});
            if (rows[i].oe_n == 6'h00) begin
                chk({2'b00, pin_out}, {2'b00, rows[i].pins});
            end
        end
        // Two transfers in a row, the second with a slow event
        wreg(OFS_INV_TMR, 8'h80);
        wreg(OFS_DC_CTRL, 8'h80);
        wreg(OFS_PORT_CTRL, 8'ha0);
        wreg(OFS_BUF_LOW, 8'h09);
        wreg(OFS_BUF_HIGH, 8'h01);
        event_wait(1'b0);
        rreg(OFS_LATCH, d);
        chk(d, 8'h19);
        wreg(OFS_BUF_LOW, 8'h06);
        wreg(OFS_BUF_HIGH, 8'h02);
        event_wait(1'b1);
        rreg(OFS_LATCH, d);
        chk(d, 8'h26);
        chk({2'b00, pin_out}, 8'h26);
        rreg(OFS_PIN_STATE, d);
        chk(d, 8'h26);
        @(posedge clk);
        #1 chk(rdata, 8'h00);
        rreg(OFS_PIN_MODE, d);
        chk(d, 8'h3f);
        rreg(OFS_BUF_HIGH, d);
        chk(d, 8'h02);
        // Field mask, unmapped place, then reset in mid-run
        wreg(OFS_DC_CTRL, 8'hff);
        rreg(OFS_DC_CTRL, d);
        chk(d, 8'hf0);
        wreg(4'hf, 8'hff);
        rreg(4'hf, d);
        chk(d, 8'h00);
        do_reset();
        rreg(OFS_DC_CTRL, d);
        chk(d, 8'h00);
        chk({2'b00, pin_oe_n}, 8'h3f);
        test_done();
    end
endmodule
